// ===== pad_config_regs.sv
`timescale 1ns/1ns
module pad_config_regs
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pad_cfg_pkg::APB_AW-1:0] paddr,
  input  wire logic [pad_cfg_pkg::APB_DW-1:0] pwdata,
  output logic      [pad_cfg_pkg::APB_DW-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [pad_cfg_pkg::CPU_AW-1:0] i_cpu_addr,
  input  wire logic                        i_port_g_pull_direction_pin,
  input  wire logic                        i_port_h_pull_direction_pin,
  input  wire logic                        i_reduced_package,
  output logic                             o_regblock_hit,
  output logic                             o_port_a_pull_up,
  output logic                             o_port_b_pull_up,
  output logic                             o_port_e_pull_up,
  output logic                             o_port_g_pull_up,
  output logic                             o_port_g_pull_down,
  output logic                             o_port_h_pull_up,
  output logic                             o_port_h_pull_down,
  output logic                             o_port_a_reduced_drive,
  output logic                             o_port_b_reduced_drive,
  output logic                             o_port_e_reduced_drive,
  output logic                             o_port_g_reduced_drive,
  output logic                             o_port_h_reduced_drive
);
  import pad_cfg_pkg::*;

  function automatic logic addr_is(input logic [APB_AW-1:0] a,
                                   input logic [7:0] idx);
    addr_is = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  logic [7:0]        pull_r;
  logic [7:0]        pull_nxt;
  logic [7:0]        drive_r;
  logic [7:0]        drive_nxt;
  logic [7:0]        base_r;
  logic [7:0]        base_nxt;
  logic [APB_DW-1:0] prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              hit_r;
  logic [6:0]        pull_out_r;
  logic [4:0]        drive_out_r;

  wire               sel_pull;
  wire               sel_drive;
  wire               sel_base;
  wire               mapped;
  wire               setup;
  wire               access_done;
  wire               wr_pull;
  wire               wr_drive;
  wire               wr_base;
  wire [7:0]         rd_byte;
  wire               hit_w;
  wire [6:0]         pull_out_w;
  wire [4:0]         drive_out_w;

  pad_ctl_if pad_if ();

  // Bus decode
  assign sel_pull    = addr_is(paddr, IDX_PULL_ENABLE);
  assign sel_drive   = addr_is(paddr, IDX_DRIVE);
  assign sel_base    = addr_is(paddr, IDX_BLOCK_BASE);
  assign mapped      = sel_pull | sel_drive | sel_base;
  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready_r;
  assign wr_pull     = access_done & pwrite & sel_pull;
  assign wr_drive    = access_done & pwrite & sel_drive;
  assign wr_base     = access_done & pwrite & sel_base;
  assign rd_byte     = sel_pull  ? pull_r  :
                       sel_drive ? drive_r :
                       sel_base  ? base_r  : 8'h00;

  assign pull_nxt  = wr_pull  ? merge(pull_r,  pwdata[7:0], PULL_WMASK)
                              : pull_r;
  assign drive_nxt = wr_drive ? merge(drive_r, pwdata[7:0], DRIVE_WMASK)
                              : drive_r;
  assign base_nxt  = wr_base  ? merge(base_r,  pwdata[7:0], BASE_WMASK)
                              : base_r;

  // Register block window decode
  assign hit_w = (i_cpu_addr[WIN_MSB:WIN_LSB] == base_r[BASE_MSB:BASE_LSB])
                 && (i_cpu_addr[SPAN_MSB:SPAN_LSB] == 2'b00);

  // Pad control hand-off to the pull resolver
  assign pad_if.pull_enable = pull_r;
  assign pad_if.dir_g_pin   = i_port_g_pull_direction_pin;
  assign pad_if.dir_h_pin   = i_port_h_pull_direction_pin;
  assign pad_if.reduced_pkg = i_reduced_package;

  pad_pull_resolve u_resolve
  (
    .p (pad_if.resolve)
  );

  assign pull_out_w  = {pad_if.h_down, pad_if.h_up, pad_if.g_down,
                        pad_if.g_up, pull_r[BIT_PULL_E],
                        pull_r[BIT_PULL_B], pull_r[BIT_PULL_A]};
  assign drive_out_w = {drive_r[BIT_RDRV_H], drive_r[BIT_RDRV_G],
                        drive_r[BIT_RDRV_E], drive_r[BIT_RDRV_B],
                        drive_r[BIT_RDRV_A]};

  // Configuration storage
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pull_r  <= PULL_RESET;
      drive_r <= DRIVE_RESET;
      base_r  <= BASE_RESET;
    end
    else
    begin
      pull_r  <= pull_nxt;
      drive_r <= drive_nxt;
      base_r  <= base_nxt;
    end
  end

  // Bus answer: ready in the first access cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup)
      begin
        prdata_r <= {24'h000000, rd_byte};
      end
    end
  end

  // Registered pad outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      hit_r       <= 1'b0;
      pull_out_r  <= 7'h00;
      drive_out_r <= 5'h00;
    end
    else
    begin
      hit_r       <= hit_w;
      pull_out_r  <= pull_out_w;
      drive_out_r <= drive_out_w;
    end
  end

  assign prdata                 = prdata_r;
  assign pready                 = pready_r;
  assign pslverr                = pslverr_r;
  assign o_regblock_hit         = hit_r;
  assign o_port_a_pull_up       = pull_out_r[0];
  assign o_port_b_pull_up       = pull_out_r[1];
  assign o_port_e_pull_up       = pull_out_r[2];
  assign o_port_g_pull_up       = pull_out_r[3];
  assign o_port_g_pull_down     = pull_out_r[4];
  assign o_port_h_pull_up       = pull_out_r[5];
  assign o_port_h_pull_down     = pull_out_r[6];
  assign o_port_a_reduced_drive = drive_out_r[0];
  assign o_port_b_reduced_drive = drive_out_r[1];
  assign o_port_e_reduced_drive = drive_out_r[2];
  assign o_port_g_reduced_drive = drive_out_r[3];
  assign o_port_h_reduced_drive = drive_out_r[4];

  // Checks
  sequence base_write_s;
    psel && penable && pready && pwrite && sel_base;
  endsequence

  sequence g_pull_on_s;
    pull_r[BIT_PULL_G] && !i_reduced_package;
  endsequence

  chk_base_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
    base_write_s |=> base_r[BASE_MSB:BASE_LSB] == $past(pwdata[BASE_MSB:BASE_LSB]))
    else $error("base select not stored");

  chk_hit_top_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cpu_addr[WIN_MSB:WIN_LSB] != base_r[BASE_MSB:BASE_LSB]) |=> !o_regblock_hit)
    else $error("hit outside selected window");

  chk_hit_low_span: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cpu_addr[WIN_MSB:WIN_LSB] == base_r[BASE_MSB:BASE_LSB])
    |=> o_regblock_hit == ($past(i_cpu_addr[SPAN_MSB:SPAN_LSB]) == 2'b00))
    else $error("hit span not first 512 bytes");

  chk_reset_base_zero: assert property (@(posedge i_clk)
    $past(i_rst) |-> base_r == BASE_RESET)
    else $error("base not zero after reset");

  chk_port_g_pull: assert property (@(posedge i_clk) disable iff (i_rst)
    g_pull_on_s ##1 $stable(pull_r)
    |-> o_port_g_pull_up == $past(i_port_g_pull_direction_pin)
        && o_port_g_pull_down == !$past(i_port_g_pull_direction_pin))
    else $error("port g pull direction wrong");

  chk_port_h_pull: assert property (@(posedge i_clk) disable iff (i_rst)
    pull_r[BIT_PULL_H] && !i_reduced_package
    |=> o_port_h_pull_up == $past(i_port_h_pull_direction_pin)
        && o_port_h_pull_down == !$past(i_port_h_pull_direction_pin))
    else $error("port h pull direction wrong");

  chk_small_pkg_g: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reduced_package && pull_r[BIT_PULL_G] |=> o_port_g_pull_up && !o_port_g_pull_down)
    else $error("port g not pulled up in small package");

  chk_small_pkg_h: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reduced_package && pull_r[BIT_PULL_H] |=> o_port_h_pull_down && !o_port_h_pull_up)
    else $error("port h not pulled down in small package");

  chk_reset_defaults: assert property (@(posedge i_clk)
    $past(i_rst) |-> pull_r == PULL_RESET && drive_r == DRIVE_RESET)
    else $error("pull or drive reset value wrong");
endmodule

// ===== pad_cfg_pkg.sv
// Behaviour
// - Register block base selectable on any 2K boundary in 64K space
// - Five base-select bits form the top five bits of block address
// - Only the lowest 512 bytes of the 2K window produce a hit
// - After reset the base is zero, first register at address zero
// - Port G pull enabled: up when direction pin high, down when low
// - Port H pull enabled: up when direction pin high, down when low
// - Reduced package ties port G direction high, giving pull-up
// - Reduced package ties port H direction low, giving pull-down
package pad_cfg_pkg;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned CPU_AW = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PULL_ENABLE = 8'h0c;
  localparam logic [7:0] IDX_DRIVE       = 8'h0d;
  localparam logic [7:0] IDX_BLOCK_BASE  = 8'h11;

  // Pull enable fields
  localparam int unsigned BIT_PULL_A = 0;
  localparam int unsigned BIT_PULL_B = 1;
  localparam int unsigned BIT_PULL_E = 4;
  localparam int unsigned BIT_PULL_G = 6;
  localparam int unsigned BIT_PULL_H = 7;
  localparam logic [7:0] PULL_WMASK = 8'hd3;
  localparam logic [7:0] PULL_RESET = 8'hd0;

  // Reduced drive fields
  localparam int unsigned BIT_RDRV_A = 0;
  localparam int unsigned BIT_RDRV_B = 1;
  localparam int unsigned BIT_RDRV_E = 3;
  localparam int unsigned BIT_RDRV_G = 5;
  localparam int unsigned BIT_RDRV_H = 6;
  localparam logic [7:0] DRIVE_WMASK = 8'h6b;
  localparam logic [7:0] DRIVE_RESET = 8'h00;

  // Block base fields
  localparam int unsigned BASE_MSB      = 7;
  localparam int unsigned BASE_LSB      = 3;
  localparam int unsigned BIT_WAIT_STOP = 0;
  localparam logic [7:0] BASE_WMASK = 8'hf9;
  localparam logic [7:0] BASE_RESET = 8'h00;

  // Block address decode
  localparam int unsigned WIN_MSB  = 15;
  localparam int unsigned WIN_LSB  = 11;
  localparam int unsigned SPAN_MSB = 10;
  localparam int unsigned SPAN_LSB = 9;

  localparam logic [4:0] NUM_DRIVE_OUT = 5'd5;
endpackage

// ===== pad_ctl_if.sv
`timescale 1ns/1ns
interface pad_ctl_if;
  logic [7:0] pull_enable;
  logic       dir_g_pin;
  logic       dir_h_pin;
  logic       reduced_pkg;
  logic       g_up;
  logic       g_down;
  logic       h_up;
  logic       h_down;

  modport regs
  (
    output pull_enable, dir_g_pin, dir_h_pin, reduced_pkg,
    input  g_up, g_down, h_up, h_down
  );
  modport resolve
  (
    input  pull_enable, dir_g_pin, dir_h_pin, reduced_pkg,
    output g_up, g_down, h_up, h_down
  );
endinterface

// ===== pad_pull_resolve.sv
`timescale 1ns/1ns
module pad_pull_resolve
(
  pad_ctl_if.resolve p
);
  import pad_cfg_pkg::*;

  wire g_dir;
  wire h_dir;
  wire g_en;
  wire h_en;

  assign g_dir = p.reduced_pkg ? 1'b1 : p.dir_g_pin;
  assign h_dir = p.reduced_pkg ? 1'b0 : p.dir_h_pin;
  assign g_en  = p.pull_enable[BIT_PULL_G];
  assign h_en  = p.pull_enable[BIT_PULL_H];

  assign p.g_up   = g_en & g_dir;
  assign p.g_down = g_en & ~g_dir;
  assign p.h_up   = h_en & h_dir;
  assign p.h_down = h_en & ~h_dir;
endmodule

// ===== pad_far_model.sv
`timescale 1ns/1ns
module pad_far_model
(
  input  wire logic                           i_clk,
  input  wire logic [pad_cfg_pkg::CPU_AW-1:0] i_addr_req,
  input  wire logic [2:0]                     i_pin_req,
  output logic      [pad_cfg_pkg::CPU_AW-1:0] o_cpu_addr,
  output logic                                o_g_dir,
  output logic                                o_h_dir,
  output logic                                o_reduced
);
  import pad_cfg_pkg::*;
  initial
  begin
    o_cpu_addr = '0;
    {o_reduced, o_h_dir, o_g_dir} = 3'h0;
  end
  // Bus address and pad pins move only just after a clock edge
  always @(posedge i_clk)
  begin
    o_cpu_addr <= i_addr_req;
    {o_reduced, o_h_dir, o_g_dir} <= i_pin_req;
  end
endmodule

// ===== pad_config_and_regblock_map_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  err_count++; $display("Error at %0t: got %h expected %h", $time, \
  got, exp); end end
module pad_config_and_regblock_map_tb;
  import pad_cfg_pkg::*;
  localparam logic [11:0] A_PULL = {2'h0, IDX_PULL_ENABLE, 2'h0};
  localparam logic [11:0] A_DRV  = {2'h0, IDX_DRIVE, 2'h0};
  localparam logic [11:0] A_BASE = {2'h0, IDX_BLOCK_BASE, 2'h0};
  logic              i_clk, i_rst, psel, penable, pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata;
  logic              pready, pslverr, hit, g_dir, h_dir, reduced;
  logic [CPU_AW-1:0] cpu_addr, addr_req;
  logic [2:0]        pin_req;
  logic [6:0]        pulls;
  logic [4:0]        rdrv;
  int                err_count = 0;
  int                n_compared = 0;
  pad_far_model u_pad_far_model (.i_clk(i_clk), .i_addr_req(addr_req),
    .i_pin_req(pin_req), .o_cpu_addr(cpu_addr), .o_g_dir(g_dir),
    .o_h_dir(h_dir), .o_reduced(reduced));
  pad_config_regs u_pad_config_regs (.i_clk(i_clk), .i_rst(i_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_cpu_addr(cpu_addr), .i_port_g_pull_direction_pin(g_dir),
    .i_port_h_pull_direction_pin(h_dir), .i_reduced_package(reduced),
    .o_regblock_hit(hit), .o_port_a_pull_up(pulls[6]),
    .o_port_b_pull_up(pulls[5]), .o_port_e_pull_up(pulls[4]),
    .o_port_g_pull_up(pulls[3]), .o_port_g_pull_down(pulls[2]),
    .o_port_h_pull_up(pulls[1]), .o_port_h_pull_down(pulls[0]),
    .o_port_a_reduced_drive(rdrv[4]), .o_port_b_reduced_drive(rdrv[3]),
    .o_port_e_reduced_drive(rdrv[2]), .o_port_g_reduced_drive(rdrv[1]),
    .o_port_h_reduced_drive(rdrv[0]));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic summarize;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      err_count++;
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp,
                    input logic exp_err);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 8'h00, q, e);
    `CHK({e, q}, {exp_err, 24'h0, exp})
  endtask
  task automatic settle;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic hit_chk(input logic [15:0] a, input logic exp);
    @(posedge i_clk);
    addr_req <= a;
    settle();
    `CHK(hit, exp)
  endtask
  initial
  begin
    #20000;
    err_count++;
    summarize();
  end
  initial
  begin
    i_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    addr_req = 16'h0100;
    pin_req = 3'h0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(A_PULL, 8'hd0, 1'b0);
    rd(A_DRV, 8'h00, 1'b0);
    rd(A_BASE, 8'h00, 1'b0);
    settle();
    `CHK({pulls, rdrv}, {7'b0010101, 5'h00})
    `CHK(hit, 1'b1)
    rd(12'h038, 8'h00, 1'b1);
    wr(A_PULL, 8'hff);
    rd(A_PULL, 8'hd3, 1'b0);
    wr(A_DRV, 8'h21);
    settle();
    `CHK(rdrv, 5'b10010)
    wr(A_DRV, 8'hff);
    rd(A_DRV, 8'h6b, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_clk);
      pin_req <= 3'(k);
      settle();
      `CHK(rdrv, 5'h1f)
      `CHK(pulls[6:4], 3'h7)
      `CHK(pulls[3:2], {k[2] | k[0], ~k[2] & ~k[0]})
      `CHK(pulls[1:0], {~k[2] & k[1], k[2] | ~k[1]})
    end
    wr(A_PULL, 8'h13);
    wr(A_DRV, 8'h00);
    settle();
    `CHK({pulls, rdrv}, {7'b1110000, 5'h00})
    hit_chk(16'h01ff, 1'b1);
    hit_chk(16'h0200, 1'b0);
    wr(A_BASE, 8'h29);
    rd(A_BASE, 8'h29, 1'b0);
    hit_chk(16'h2800, 1'b1);
    hit_chk(16'h29ff, 1'b1);
    hit_chk(16'h2a00, 1'b0);
    hit_chk(16'ha800, 1'b0);
    hit_chk(16'h0100, 1'b0);
    wr(A_BASE, 8'hff);
    rd(A_BASE, 8'hf9, 1'b0);
    hit_chk(16'hf9ff, 1'b1);
    hit_chk(16'hfa00, 1'b0);
    summarize();
  end
endmodule
